// ---- logic/hsspwm_pkg.sv ----
// constants, register map and timing for the high-side switch source block
// assumes a 100 MHz system clock and a byte-wide register port
// Behaviour
// - selector 000 off, 001 on
// - selectors 010/011 follow cyclic timers
// - selectors 100/101 follow duty generators
// - selectors at 2:0 and 6:4, 7/3 zero
// - overcurrent or overtemperature clears switch selector
// - fail duty field: 20, 10, 5, 2.5 percent
// - second pin codes 000-011 carry third fail
// - first pin codes 000-011 carry second fail
// - pin code 100 switches pin off
// - pin code 101 is wake, 16us filter
// - pin code 110 low-side, 111 high-side on
// - duty 0 off, FF on, else N/255
// - switch bytes clear on reset and restart
// - pin and duty bytes survive restart
// - frequency bit: 0 200Hz, 1 400Hz
// - period codes 10ms to 2s, 111 reserved
// - on-time codes low, 0.1-20ms, high
// - assigned timer starts once on-time written
package hsspwm_pkg;
  // register offsets
  localparam logic [6:0] OFS_TIMER_FIRST = 7'h0C;
  localparam logic [6:0] OFS_TIMER_SECOND = 7'h0D;
  localparam logic [6:0] OFS_SRC_SEL_A = 7'h14;
  localparam logic [6:0] OFS_SRC_SEL_B = 7'h15;
  localparam logic [6:0] OFS_GP_CFG = 7'h17;
  localparam logic [6:0] OFS_DUTY_FIRST = 7'h18;
  localparam logic [6:0] OFS_DUTY_SECOND = 7'h19;
  localparam logic [6:0] OFS_DUTY_FREQ = 7'h1C;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // field positions
  localparam int SEL_LO_POS = 0;
  localparam int SEL_HI_POS = 4;
  localparam int GP_FIRST_POS = 0;
  localparam int GP_SECOND_POS = 3;
  localparam int FAIL_OUT_DUTY_SEL_POS = 6;
  localparam int TMR_PER_POS = 0;
  localparam int TMR_ON_POS = 4;
  localparam int FREQ_FIRST_POS = 0;
  localparam int FREQ_SECOND_POS = 2;
  localparam logic [7:0] SEL_MASK = 8'h77;
  localparam logic [7:0] FREQ_MASK = 8'h05;
  // switch source codes
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_ON = 3'h1;
  localparam logic [2:0] SRC_TMR1 = 3'h2;
  localparam logic [2:0] SRC_TMR2 = 3'h3;
  localparam logic [2:0] SRC_DUTY1 = 3'h4;
  localparam logic [2:0] SRC_DUTY2 = 3'h5;
  // general pin codes
  localparam logic [2:0] GP_OFF = 3'h4;
  localparam logic [2:0] GP_WAKE = 3'h5;
  localparam logic [2:0] GP_LOW_SIDE = 3'h6;
  localparam logic [2:0] GP_HIGH_SIDE = 3'h7;
  // timer on-time codes at the ends, and the reserved period code
  localparam logic [2:0] TON_LOW = 3'h0;
  localparam logic [2:0] TON_HIGH = 3'h6;
  localparam logic [2:0] TPER_RSVD = 3'h7;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 100000;
  localparam int TICK_CYC = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int WAKE_FILT_TIME_NS = 16000;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DUTY_PERIOD_SLOW_NS = 5000000;
  localparam int DUTY_STEPS = 255;
  localparam int DUTY_STEP_CYC = DUTY_PERIOD_SLOW_NS / CLK_PERIOD_NS / DUTY_STEPS;
  localparam int FAIL_PERIOD_NS = 1000000000;
  localparam int FAIL_PERIOD_CYC = FAIL_PERIOD_NS / CLK_PERIOD_NS;
  // period and on-time tables in 0.1 ms ticks, indexed by code
  localparam logic [14:0] PER_TICKS [8] = '{15'd100, 15'd200, 15'd500, 15'd1000,
                                            15'd2000, 15'd10000, 15'd20000, 15'd0};
  localparam logic [14:0] ON_TICKS [8] = '{15'd0, 15'd1, 15'd3, 15'd10,
                                           15'd100, 15'd200, 15'd0, 15'd0};
  // fail output on-time divisors for 20, 10, 5, 2.5 percent
  localparam int FAIL_DIV [4] = '{5, 10, 20, 40};
endpackage

// ---- logic/hsspwm_duty_if.sv ----
// carrier between the control block and one duty-cycle generator
// assumes both ends share clk_sys
`timescale 1ns/100ps
interface hsspwm_duty_if;
  logic [7:0] duty;
  logic fast;
  logic out;
  modport gen (input duty, input fast, output out);
  modport ctl (output duty, output fast, input out);
endinterface

// ---- logic/hsspwm_duty_gen.sv ----
// one 8-bit duty-cycle generator, 255 steps per period
// assumes duty and fast come from registers on clk_sys
`timescale 1ns/100ps
module hsspwm_duty_gen
  import hsspwm_pkg::*;
#(
  parameter int STEP_CYC = DUTY_STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  hsspwm_duty_if.gen dg
);
  if (STEP_CYC < 4 || STEP_CYC > 65535) begin : g_chk
    $error("duty step count out of range");
  end

  logic [15:0] step_reg;
  logic [7:0] phase_reg;
  logic out_reg;
  logic [15:0] step_last;

  // the fast setting halves every step, doubling the rate
  assign step_last = dg.fast ? 16'(STEP_CYC / 2 - 1) : 16'(STEP_CYC - 1);

  // step prescaler and phase 0..254
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      step_reg <= 16'h0000;
      phase_reg <= 8'h00;
    end else if (step_reg >= step_last) begin
      step_reg <= 16'h0000;
      phase_reg <= (phase_reg == 8'(DUTY_STEPS - 1)) ? 8'h00 : phase_reg + 8'h01;
    end else begin
      step_reg <= step_reg + 16'h0001;
    end
  end

  // on while phase below duty; FF is on throughout
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= (dg.duty == 8'hFF) || (phase_reg < dg.duty);
    end
  end

  assign dg.out = out_reg;
endmodule

// ---- logic/hsspwm_top.sv ----
// high-side switch source selection, cyclic timers, duty generators and
// general pin configuration
// assumes a byte register port from the serial link decoder on clk_sys;
// fault and pin inputs are asynchronous
`timescale 1ns/100ps
module hsspwm_top
  import hsspwm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int DUTY_STEP_CYCLES = DUTY_STEP_CYC,
  parameter int FAIL_PERIOD_CYCLES = FAIL_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic restart_entry,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] hs_fault_pin,
  input wire logic fail_req,
  input wire logic fail_output_second,
  input wire logic [1:0] gp_pin_in,
  output logic high_side_out_one,
  output logic high_side_out_two,
  output logic high_side_out_three,
  output logic high_side_out_four,
  output logic [1:0] gp_fail_drive,
  output logic [1:0] gp_low_side_on,
  output logic [1:0] gp_high_side_on,
  output logic [1:0] gp_wake_pulse
);
  if (TICK_CYCLES < 2 || TICK_CYCLES > 16383) begin : g_chk_tick
    $error("tick count out of range");
  end
  if (FAIL_PERIOD_CYCLES < 40 || FAIL_PERIOD_CYCLES > 268435455) begin : g_chk_fail
    $error("fail period out of range");
  end

  logic [7:0] src_sel_a_reg;
  logic [7:0] src_sel_b_reg;
  logic [7:0] gp_cfg_reg;
  logic [7:0] duty_reg [2];
  logic [7:0] duty_freq_reg;
  logic [7:0] timer_reg [2];
  logic [7:0] reg_rdata_reg;
  logic [3:0] fault_s1_reg;
  logic [3:0] fault_s2_reg;
  logic [2:0] sel [4];
  logic [3:0] hs_reg;
  logic [1:0] tmr_out;
  logic [1:0] duty_out;
  logic [1:0] tmr_assigned;
  logic soft_clear;
  logic wr_sel_a;
  logic wr_sel_b;

  assign soft_clear = reset || soft_reset;
  assign wr_sel_a = reg_wr_en && (reg_addr == OFS_SRC_SEL_A);
  assign wr_sel_b = reg_wr_en && (reg_addr == OFS_SRC_SEL_B);

  // fault pins pass two flops before use
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fault_s1_reg <= 4'h0;
      fault_s2_reg <= 4'h0;
    end else begin
      fault_s1_reg <= hs_fault_pin;
      fault_s2_reg <= fault_s1_reg;
    end
  end

  // switch selector byte a: cleared by resets and restart, each field cleared by its fault
  always_ff @(posedge clk_sys) begin
    if (soft_clear || restart_entry) begin
      src_sel_a_reg <= RESET_BYTE;
    end else begin
      if (wr_sel_a) begin
        src_sel_a_reg <= reg_wdata & SEL_MASK;
      end
      if (fault_s2_reg[0]) begin
        src_sel_a_reg[SEL_LO_POS +: 3] <= SRC_OFF;
      end
      if (fault_s2_reg[1]) begin
        src_sel_a_reg[SEL_HI_POS +: 3] <= SRC_OFF;
      end
    end
  end

  // switch selector byte b, same behaviour for switches three and four
  always_ff @(posedge clk_sys) begin
    if (soft_clear || restart_entry) begin
      src_sel_b_reg <= RESET_BYTE;
    end else begin
      if (wr_sel_b) begin
        src_sel_b_reg <= reg_wdata & SEL_MASK;
      end
      if (fault_s2_reg[2]) begin
        src_sel_b_reg[SEL_LO_POS +: 3] <= SRC_OFF;
      end
      if (fault_s2_reg[3]) begin
        src_sel_b_reg[SEL_HI_POS +: 3] <= SRC_OFF;
      end
    end
  end

  // pin config, duty and frequency bytes survive restart
  always_ff @(posedge clk_sys) begin
    if (soft_clear) begin
      gp_cfg_reg <= RESET_BYTE;
      duty_reg[0] <= RESET_BYTE;
      duty_reg[1] <= RESET_BYTE;
      duty_freq_reg <= RESET_BYTE;
    end else if (reg_wr_en) begin
      if (reg_addr == OFS_GP_CFG) begin
        gp_cfg_reg <= reg_wdata;
      end
      if (reg_addr == OFS_DUTY_FIRST) begin
        duty_reg[0] <= reg_wdata;
      end
      if (reg_addr == OFS_DUTY_SECOND) begin
        duty_reg[1] <= reg_wdata;
      end
      if (reg_addr == OFS_DUTY_FREQ) begin
        duty_freq_reg <= reg_wdata & FREQ_MASK;
      end
    end
  end

  // timer control bytes, cleared on restart as well
  always_ff @(posedge clk_sys) begin
    if (soft_clear || restart_entry) begin
      timer_reg[0] <= RESET_BYTE;
      timer_reg[1] <= RESET_BYTE;
    end else if (reg_wr_en) begin
      if (reg_addr == OFS_TIMER_FIRST) begin
        timer_reg[0] <= reg_wdata & SEL_MASK;
      end
      if (reg_addr == OFS_TIMER_SECOND) begin
        timer_reg[1] <= reg_wdata & SEL_MASK;
      end
    end
  end

  // read port: data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        OFS_TIMER_FIRST: reg_rdata_reg <= timer_reg[0];
        OFS_TIMER_SECOND: reg_rdata_reg <= timer_reg[1];
        OFS_SRC_SEL_A: reg_rdata_reg <= src_sel_a_reg;
        OFS_SRC_SEL_B: reg_rdata_reg <= src_sel_b_reg;
        OFS_GP_CFG: reg_rdata_reg <= gp_cfg_reg;
        OFS_DUTY_FIRST: reg_rdata_reg <= duty_reg[0];
        OFS_DUTY_SECOND: reg_rdata_reg <= duty_reg[1];
        OFS_DUTY_FREQ: reg_rdata_reg <= duty_freq_reg;
        default: reg_rdata_reg <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = reg_rdata_reg;

  // selector per switch
  assign sel[0] = src_sel_a_reg[SEL_LO_POS +: 3];
  assign sel[1] = src_sel_a_reg[SEL_HI_POS +: 3];
  assign sel[2] = src_sel_b_reg[SEL_LO_POS +: 3];
  assign sel[3] = src_sel_b_reg[SEL_HI_POS +: 3];

  // a timer counts only while some switch follows it
  always_comb begin
    tmr_assigned = 2'b00;
    for (int i = 0; i < 4; i++) begin
      if (sel[i] == SRC_TMR1) begin
        tmr_assigned[0] = 1'b1;
      end
      if (sel[i] == SRC_TMR2) begin
        tmr_assigned[1] = 1'b1;
      end
    end
  end

  // shared 0.1 ms tick for both cyclic timers
  logic [13:0] tick_cnt_reg;
  logic tick;
  assign tick = (tick_cnt_reg == 14'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys) begin
    if (reset || tick) begin
      tick_cnt_reg <= 14'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 14'h0001;
    end
  end

  // cyclic timers
  for (genvar t = 0; t < 2; t++) begin : g_tmr
    logic [2:0] per_code;
    logic [2:0] on_code;
    logic running;
    logic [14:0] cnt_reg;
    logic out_reg;
    assign per_code = timer_reg[t][TMR_PER_POS +: 3];
    assign on_code = timer_reg[t][TMR_ON_POS +: 3];
    // runs once assigned and a running on-time is written
    assign running = tmr_assigned[t] && (on_code != TON_LOW) && (on_code < TON_HIGH)
                     && (per_code != TPER_RSVD);
    always_ff @(posedge clk_sys) begin
      if (reset || !running) begin
        cnt_reg <= 15'h0000;
      end else if (tick) begin
        cnt_reg <= (cnt_reg >= PER_TICKS[per_code] - 15'h0001) ? 15'h0000 : cnt_reg + 15'h0001;
      end
    end
    // high for the on-time at the start of each period
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        out_reg <= 1'b0;
      end else if (on_code == TON_HIGH) begin
        out_reg <= 1'b1;
      end else begin
        out_reg <= running && (cnt_reg < ON_TICKS[on_code]);
      end
    end
    assign tmr_out[t] = out_reg;
  end

  // duty generators
  for (genvar d = 0; d < 2; d++) begin : g_duty
    hsspwm_duty_if dif ();
    assign dif.duty = duty_reg[d];
    assign dif.fast = duty_freq_reg[d * 2];
    assign duty_out[d] = dif.out;
    hsspwm_duty_gen #(
      .STEP_CYC(DUTY_STEP_CYCLES)
    ) u_gen (
      .clk_sys(clk_sys),
      .reset(soft_clear),
      .dg(dif.gen)
    );
  end

  // switch output multiplexer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hs_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        case (sel[i])
          SRC_OFF: hs_reg[i] <= 1'b0;
          SRC_ON: hs_reg[i] <= 1'b1;
          SRC_TMR1: hs_reg[i] <= tmr_out[0];
          SRC_TMR2: hs_reg[i] <= tmr_out[1];
          SRC_DUTY1: hs_reg[i] <= duty_out[0];
          SRC_DUTY2: hs_reg[i] <= duty_out[1];
          default: hs_reg[i] <= 1'b0;
        endcase
      end
    end
  end
  assign high_side_out_one = hs_reg[0];
  assign high_side_out_two = hs_reg[1];
  assign high_side_out_three = hs_reg[2];
  assign high_side_out_four = hs_reg[3];

  // third fail output: pulsed at the selected duty while fail is requested
  logic [27:0] fail_cnt_reg;
  logic [27:0] fail_on_cyc;
  logic fail_third;
  logic [1:0] fail_out_duty_sel;
  assign fail_out_duty_sel = gp_cfg_reg[FAIL_OUT_DUTY_SEL_POS +: 2];
  always_comb begin
    case (fail_out_duty_sel)
      2'h0: fail_on_cyc = 28'(FAIL_PERIOD_CYCLES / FAIL_DIV[0]);
      2'h1: fail_on_cyc = 28'(FAIL_PERIOD_CYCLES / FAIL_DIV[1]);
      2'h2: fail_on_cyc = 28'(FAIL_PERIOD_CYCLES / FAIL_DIV[2]);
      default: fail_on_cyc = 28'(FAIL_PERIOD_CYCLES / FAIL_DIV[3]);
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset || !fail_req) begin
      fail_cnt_reg <= 28'h0000000;
    end else if (fail_cnt_reg == 28'(FAIL_PERIOD_CYCLES - 1)) begin
      fail_cnt_reg <= 28'h0000000;
    end else begin
      fail_cnt_reg <= fail_cnt_reg + 28'h0000001;
    end
  end
  assign fail_third = fail_req && (fail_cnt_reg < fail_on_cyc);

  // general pins: mode decode, wake filtering, drives
  for (genvar g = 0; g < 2; g++) begin : g_pin
    logic [2:0] mode;
    logic s1_reg;
    logic s2_reg;
    logic stable_reg;
    logic [10:0] filt_cnt_reg;
    logic fail_src;
    assign mode = gp_cfg_reg[(g == 0 ? GP_FIRST_POS : GP_SECOND_POS) +: 3];
    assign fail_src = (g == 0) ? fail_output_second : fail_third;
    // pin input through two flops
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
      end else begin
        s1_reg <= gp_pin_in[g];
        s2_reg <= s1_reg;
      end
    end
    // static filter: in wake mode a new level must hold 16 us before it is taken
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        filt_cnt_reg <= 11'h000;
        stable_reg <= 1'b0;
        gp_wake_pulse[g] <= 1'b0;
      end else begin
        gp_wake_pulse[g] <= 1'b0;
        if (s2_reg == stable_reg || mode != GP_WAKE) begin
          filt_cnt_reg <= 11'h000;
          if (mode != GP_WAKE) begin
            stable_reg <= s2_reg;
          end
        end else if (filt_cnt_reg == 11'(WAKE_FILT_CYC - 1)) begin
          filt_cnt_reg <= 11'h000;
          stable_reg <= s2_reg;
          gp_wake_pulse[g] <= 1'b1;
        end else begin
          filt_cnt_reg <= filt_cnt_reg + 11'h001;
        end
      end
    end
    // pin drives by mode
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        gp_fail_drive[g] <= 1'b0;
        gp_low_side_on[g] <= 1'b0;
        gp_high_side_on[g] <= 1'b0;
      end else begin
        gp_fail_drive[g] <= (mode < GP_OFF) && fail_src;
        gp_low_side_on[g] <= (mode == GP_LOW_SIDE);
        gp_high_side_on[g] <= (mode == GP_HIGH_SIDE);
      end
    end
  end
endmodule

// ---- tb/hsspwm_properties.sv ----
// checker for the high-side switch source block, bound to its top ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
module hsspwm_checker
  import hsspwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic restart_entry,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] hs_fault_pin,
  input wire logic high_side_out_one,
  input wire logic high_side_out_two,
  input wire logic high_side_out_three,
  input wire logic high_side_out_four,
  input wire logic [1:0] gp_fail_drive,
  input wire logic [1:0] gp_low_side_on,
  input wire logic [1:0] gp_high_side_on
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // write of a lower selector code to the first control byte
  sequence s_wr_sel(logic [2:0] code);
    reg_wr_en && reg_addr == OFS_SRC_SEL_A && reg_wdata[2:0] == code;
  endsequence
  // write of the first pin field of the pin configuration byte
  sequence s_wr_pin(logic [2:0] code);
    reg_wr_en && reg_addr == OFS_GP_CFG && reg_wdata[2:0] == code;
  endsequence
  // fault held long enough to pass the synchroniser and clear
  sequence s_fault_held;
    hs_fault_pin[0] [*4];
  endsequence

  a_sel_on: assert property (s_wr_sel(SRC_ON) |-> ##2 high_side_out_one)
    else $error("switch one not on after on code");
  a_sel_off: assert property (s_wr_sel(SRC_OFF) |-> ##2 !high_side_out_one)
    else $error("switch one not off after off code");
  a_rsvd_zero: assert property (reg_rd_en && (reg_addr == OFS_SRC_SEL_A || reg_addr == OFS_SRC_SEL_B)
    |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
    else $error("reserved selector bits read as one");
  a_unmapped_read: assert property (reg_rd_en && reg_addr == 7'h7F |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_fault_clear: assert property (s_fault_held |=> !high_side_out_one)
    else $error("switch one still on under fault");
  a_pin_off: assert property (s_wr_pin(GP_OFF) |-> ##2
    {gp_fail_drive[0], gp_low_side_on[0], gp_high_side_on[0]} == 3'h0)
    else $error("pin one not off");
  a_pin_low_side: assert property (s_wr_pin(GP_LOW_SIDE) |-> ##2 gp_low_side_on[0] && !gp_high_side_on[0])
    else $error("pin one low-side not on");
  a_pin_high_side: assert property (reg_wr_en && reg_addr == OFS_GP_CFG && reg_wdata[5:3] == GP_HIGH_SIDE
    |-> ##2 gp_high_side_on[1] && !gp_low_side_on[1])
    else $error("pin two high-side not on");
  a_restart_off: assert property (restart_entry |-> ##2
    {high_side_out_one, high_side_out_two, high_side_out_three, high_side_out_four} == 4'h0)
    else $error("switch on after restart");
  a_soft_clear: assert property (soft_reset |-> ##2 gp_low_side_on == 2'h0 && gp_high_side_on == 2'h0)
    else $error("pin switch on after soft reset");
endmodule

// ---- tb/hsspwm_load_model.sv ----
// loads on the four high-side outputs: meters conduction, can overheat
// assumes the bench pulses fault_cmd while a switch conducts
`timescale 1ns/100ps
module hsspwm_load_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clr,
  input wire logic [3:0] drive,
  input wire logic [3:0] fault_cmd,
  output logic [3:0] hs_fault_pin,
  output int on_cnt [4],
  output int rise_cnt [4]
);
  logic [3:0] prev_reg;
  logic [2:0] heat_reg [4];

  // conduction and turn-on metering, overtemperature held for 7 cycles
  always_ff @(posedge clk_sys) begin
    prev_reg <= drive;
    for (int i = 0; i < 4; i++) begin
      on_cnt[i] <= clr ? 0 : on_cnt[i] + int'(drive[i] === 1'b1);
      rise_cnt[i] <= clr ? 0 : rise_cnt[i] + int'(drive[i] === 1'b1 && prev_reg[i] === 1'b0);
      if (reset) begin
        heat_reg[i] <= 3'h0;
      end else if (fault_cmd[i] && drive[i]) begin
        heat_reg[i] <= 3'h7;
      end else if (heat_reg[i] != 3'h0) begin
        heat_reg[i] <= heat_reg[i] - 3'h1;
      end
    end
  end

  // fault line high while the load is hot
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hs_fault_pin[i] = (heat_reg[i] != 3'h0);
    end
  end
endmodule

// ---- tb/tb_hsspwm_top.sv ----
// self-checking bench for the high-side switch source block
// assumes short tick, duty step and fail period parameters
`timescale 1ns/100ps
module tb_hsspwm_top;
  import hsspwm_pkg::*;
  logic clk_sys, reset = 1'b1, soft_reset = 1'b0, restart_entry = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, fail_req = 1'b0, fail_output_second = 1'b0, clr = 1'b0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [3:0] hs_fault_pin, hs_out, fault_cmd = 4'h0;
  logic [1:0] gp_pin_in = 2'h0, gp_fail_drive, gp_low_side_on, gp_high_side_on, gp_wake_pulse;
  int on_cnt [4], rise_cnt [4];
  int n_fail = 0, check_count = 0;

  hsspwm_top #(.TICK_CYCLES(10), .DUTY_STEP_CYCLES(8), .FAIL_PERIOD_CYCLES(400)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .soft_reset(soft_reset), .restart_entry(restart_entry),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .hs_fault_pin(hs_fault_pin), .fail_req(fail_req),
    .fail_output_second(fail_output_second), .gp_pin_in(gp_pin_in),
    .high_side_out_one(hs_out[0]), .high_side_out_two(hs_out[1]), .high_side_out_three(hs_out[2]),
    .high_side_out_four(hs_out[3]), .gp_fail_drive(gp_fail_drive), .gp_low_side_on(gp_low_side_on),
    .gp_high_side_on(gp_high_side_on), .gp_wake_pulse(gp_wake_pulse));

  hsspwm_load_model i_load (.clk_sys(clk_sys), .reset(reset), .clr(clr), .drive(hs_out),
    .fault_cmd(fault_cmd), .hs_fault_pin(hs_fault_pin), .on_cnt(on_cnt), .rise_cnt(rise_cnt));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // only selector codes 000-101 are written; duty values include 00 and FF
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    @(negedge clk_sys);
    check(reg_rdata === exp, msg);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // meter one switch over a window; rises below zero are not judged
  task automatic measure(input int ch, input int cyc, input int exp, input int rises, input string msg);
    repeat (4) @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (cyc) @(posedge clk_sys);
    @(negedge clk_sys);
    check(on_cnt[ch] >= exp - 2 && on_cnt[ch] <= exp + 2, msg);
    if (rises >= 0) check(rise_cnt[ch] == rises, msg);
  endtask

  task automatic t_select;
    rd(OFS_SRC_SEL_B, 8'h00, "sel b reset");
    rd(OFS_DUTY_SECOND, 8'h00, "duty two reset");
    wr(OFS_SRC_SEL_A, 8'hDD);
    rd(OFS_SRC_SEL_A, 8'h55, "reserved bits");
    rd(7'h7F, 8'h00, "unmapped read");
    wr(OFS_SRC_SEL_A, 8'h01);
    settle();
    check(hs_out === 4'h1, "on code");
    wr(OFS_SRC_SEL_A, 8'h10);
    wr(OFS_SRC_SEL_B, 8'h11);
    settle();
    check(hs_out === 4'hE, "upper field");
    wr(OFS_SRC_SEL_A, 8'h11);
    @(posedge clk_sys);
    fault_cmd <= 4'h1;
    @(posedge clk_sys);
    fault_cmd <= 4'h0;
    repeat (12) @(posedge clk_sys);
    rd(OFS_SRC_SEL_A, 8'h10, "fault clear");
    check(hs_out === 4'hE, "fault output");
    $display("test select done");
  endtask

  task automatic t_duty;
    wr(OFS_SRC_SEL_B, 8'h00);
    wr(OFS_DUTY_FIRST, 8'hFF);
    wr(OFS_SRC_SEL_A, 8'h04);
    measure(0, 2040, 2040, 0, "duty full");
    wr(OFS_DUTY_FIRST, 8'h00);
    measure(0, 2040, 0, 0, "duty zero");
    wr(OFS_DUTY_FIRST, 8'h80);
    measure(0, 2040, 1024, 1, "duty half slow");
    wr(OFS_DUTY_FREQ, 8'h01);
    measure(0, 2040, 1024, 2, "duty half fast");
    wr(OFS_DUTY_SECOND, 8'h40);
    wr(OFS_SRC_SEL_A, 8'h54);
    measure(1, 2040, 512, 1, "duty two");
    $display("test duty done");
  endtask

  // timers are assigned before their on-time is written
  task automatic t_timer;
    wr(OFS_SRC_SEL_A, 8'h02);
    wr(OFS_TIMER_FIRST, 8'h10);
    measure(0, 2000, 20, 2, "timer one");
    wr(OFS_SRC_SEL_A, 8'h03);
    wr(OFS_TIMER_SECOND, 8'h31);
    measure(0, 2000, 100, 1, "timer two");
    wr(OFS_TIMER_SECOND, 8'h60);
    measure(0, 200, 200, -1, "timer high");
    wr(OFS_TIMER_SECOND, 8'h00);
    measure(0, 200, 0, -1, "timer low");
    $display("test timer done");
  endtask

  // fail duty codes swept with both pins in fail modes; wake filter timed last
  task automatic t_pins;
    int exp_on [4] = '{80, 40, 20, 10};
    int n;
    @(posedge clk_sys);
    fail_req <= 1'b1;
    fail_output_second <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_GP_CFG, {c[1:0], 3'(c), 3'(c)});
      settle();
      check(gp_fail_drive[0] === 1'b1, "second fail on pin");
      n = 0;
      repeat (400) begin
        @(negedge clk_sys);
        n += int'(gp_fail_drive[1] === 1'b1);
      end
      check(n >= exp_on[c] - 2 && n <= exp_on[c] + 2, "third fail duty");
    end
    wr(OFS_GP_CFG, 8'h24);
    settle();
    check({gp_fail_drive, gp_low_side_on, gp_high_side_on} === 6'h0, "pins off");
    wr(OFS_GP_CFG, 8'h3E);
    settle();
    check({gp_low_side_on, gp_high_side_on} === 4'h6, "pin switches");
    wr(OFS_GP_CFG, 8'h2D);
    settle();
    @(posedge clk_sys);
    gp_pin_in <= 2'h1;
    n = 0;
    // pulse is one cycle wide, so it is looked at between edges
    while (gp_wake_pulse[0] !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    check(n >= 1600 && n <= 1608, "wake filter");
    $display("test pins done");
  endtask

  task automatic t_restart;
    wr(OFS_GP_CFG, 8'h3E);
    wr(OFS_DUTY_FIRST, 8'h5A);
    wr(OFS_SRC_SEL_A, 8'h11);
    wr(OFS_SRC_SEL_B, 8'h22);
    @(posedge clk_sys);
    restart_entry <= 1'b1;
    @(posedge clk_sys);
    restart_entry <= 1'b0;
    rd(OFS_SRC_SEL_A, 8'h00, "restart sel a");
    rd(OFS_SRC_SEL_B, 8'h00, "restart sel b");
    rd(OFS_GP_CFG, 8'h3E, "restart pins");
    rd(OFS_DUTY_FIRST, 8'h5A, "restart duty");
    @(posedge clk_sys);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    rd(OFS_GP_CFG, 8'h00, "soft pins");
    rd(OFS_DUTY_FIRST, 8'h00, "soft duty");
    $display("test restart done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    t_select();
    t_duty();
    t_timer();
    t_pins();
    t_restart();
    tally_and_finish();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    $display("unexpected at %0t: timeout", $time);
    tally_and_finish();
  end
endmodule

bind hsspwm_top hsspwm_checker i_chk (.clk_sys(clk_sys), .reset(reset), .soft_reset(soft_reset),
  .restart_entry(restart_entry), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .hs_fault_pin(hs_fault_pin),
  .high_side_out_one(high_side_out_one), .high_side_out_two(high_side_out_two),
  .high_side_out_three(high_side_out_three), .high_side_out_four(high_side_out_four),
  .gp_fail_drive(gp_fail_drive), .gp_low_side_on(gp_low_side_on), .gp_high_side_on(gp_high_side_on));
